// ==== bpsc_pkg.sv ====
package bpsc_pkg;

  // Field widths
  localparam int unsigned BPSC_POS_W = 8;
  localparam int unsigned BPSC_ALIVE_W = 2;
  localparam int unsigned BPSC_RTYPE_W = 2;
  localparam int unsigned BPSC_GEAR_W = 4;

  // Pedal position end points
  localparam logic [BPSC_POS_W-1:0] BPSC_POS_REST = 8'h00;
  localparam logic [BPSC_POS_W-1:0] BPSC_POS_FULL = 8'hff;

  // Request type encodings
  localparam logic [BPSC_RTYPE_W-1:0] BPSC_RT_NONE = 2'h0;
  localparam logic [BPSC_RTYPE_W-1:0] BPSC_RT_MAX = 2'h1;
  localparam logic [BPSC_RTYPE_W-1:0] BPSC_RT_MIN = 2'h2;
  localparam logic [BPSC_RTYPE_W-1:0] BPSC_RT_HOLD = 2'h3;

  // Requested gear encodings
  localparam logic [BPSC_GEAR_W-1:0] BPSC_GEAR_NONE = 4'h0;
  localparam logic [BPSC_GEAR_W-1:0] BPSC_GEAR_FIRST = 4'h1;
  localparam logic [BPSC_GEAR_W-1:0] BPSC_GEAR_LAST = 4'h8;

  // Alive count reset value and step
  localparam logic [BPSC_ALIVE_W-1:0] BPSC_ALIVE_RST = 2'h0;
  localparam logic [BPSC_ALIVE_W-1:0] BPSC_ALIVE_STEP = 2'h1;

  // Transmission period
  localparam int unsigned BPSC_CLK_HZ = 50_000_000;
  localparam int unsigned BPSC_TX_PERIOD_MS = 15;
  localparam int unsigned BPSC_TX_PERIOD_CYC = (BPSC_CLK_HZ / 1000) * BPSC_TX_PERIOD_MS;
  localparam int unsigned BPSC_CNT_W = 20;

  typedef struct packed {
    logic [BPSC_RTYPE_W-1:0] req_type;
    logic [BPSC_GEAR_W-1:0] req_gear;
  } bpsc_gear_t;

  typedef struct packed {
    logic init_travel;
    logic init_invalid;
    logic mod_travel;
    logic mod_invalid;
    logic [BPSC_POS_W-1:0] position;
    logic [BPSC_ALIVE_W-1:0] alive;
    bpsc_gear_t gear;
  } bpsc_frame_t;

endpackage

// ==== bpsc_sync.sv ====
`timescale 1ns/10ps
module bpsc_sync #(
  parameter int unsigned W = 1
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;
  logic [W-1:0] next_q;

  // A bit changes only when the second and third stages agree
  always_comb begin
    next_q = ((s2 ~^ s3) & s3) | ((s2 ^ s3) & q_o);
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
      q_o <= '0;
    end else begin
      s1 <= d_i;
      s2 <= s1;
      s3 <= s2;
      q_o <= next_q;
    end
  end
endmodule // bpsc_sync

// ==== bpsc_top.sv ====
`timescale 1ns/10ps
module bpsc_top import bpsc_pkg::*; #(
  parameter int unsigned TX_PERIOD_CYC = BPSC_TX_PERIOD_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [BPSC_POS_W-1:0] pedal_pos_i,
  input wire logic brake_switch_i,
  input wire logic sensor_fitted_i,
  input wire logic discrete_only_i,
  input wire logic [BPSC_POS_W-1:0] init_thresh_i,
  input wire logic [BPSC_POS_W-1:0] mod_thresh_i,
  input wire logic init_diag_fail_i,
  input wire logic init_fault_stored_i,
  input wire logic mod_diag_fail_i,
  input wire logic mod_fault_stored_i,
  input wire logic shift_ctrl_en_i,
  input wire bpsc_gear_t gear_req_i,
  output bpsc_frame_t frame_o,
  output logic frame_strobe_o
);

  function automatic logic bpsc_crossed(input logic [BPSC_POS_W-1:0] pos,
                                        input logic [BPSC_POS_W-1:0] thr);
    bpsc_crossed = (pos >= thr);
  endfunction

  // Active request type with a real gear
  function automatic logic bpsc_gear_ok(input bpsc_gear_t req);
    bpsc_gear_ok = (req.req_type != BPSC_RT_NONE)
                   && (req.req_gear >= BPSC_GEAR_FIRST)
                   && (req.req_gear <= BPSC_GEAR_LAST);
  endfunction

  logic [BPSC_POS_W-1:0] pos_s;
  logic sw_s;

  // Pin inputs from the sensor and the redundant switch
  bpsc_sync #(.W(BPSC_POS_W + 1)) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i({pedal_pos_i, brake_switch_i}),
    .q_o({pos_s, sw_s})
  );

  // Transmission period divider
  logic [BPSC_CNT_W-1:0] cnt;
  logic [BPSC_CNT_W-1:0] next_cnt;
  logic tick;

  always_comb begin
    tick = (cnt == BPSC_CNT_W'(TX_PERIOD_CYC - 1));
    next_cnt = tick ? '0 : cnt + BPSC_CNT_W'(1);
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt <= '0;
    end else begin
      cnt <= next_cnt;
    end
  end

  // Frame formation
  bpsc_frame_t next_frame;
  logic next_strobe;

  always_comb begin
    next_frame = frame_o;
    next_strobe = tick;
    if (tick) begin
      next_frame.init_travel = sw_s
                               || (sensor_fitted_i && bpsc_crossed(pos_s, init_thresh_i));
      next_frame.init_invalid = init_diag_fail_i && init_fault_stored_i;
      if (sensor_fitted_i) begin
        next_frame.mod_travel = bpsc_crossed(pos_s, mod_thresh_i);
        next_frame.mod_invalid = mod_diag_fail_i && mod_fault_stored_i;
      end else begin
        next_frame.mod_travel = 1'b0;
        next_frame.mod_invalid = 1'b0;
      end
      if (discrete_only_i) begin
        next_frame.position = sw_s ? BPSC_POS_FULL : BPSC_POS_REST;
      end else begin
        next_frame.position = pos_s;
      end
      next_frame.alive = frame_o.alive + BPSC_ALIVE_STEP;
      next_frame.gear.req_type = BPSC_RT_NONE;
      next_frame.gear.req_gear = BPSC_GEAR_NONE;
      if (shift_ctrl_en_i && bpsc_gear_ok(gear_req_i)) begin
        next_frame.gear = gear_req_i;
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      frame_o <= '0;
      frame_strobe_o <= 1'b0;
    end else begin
      frame_o <= next_frame;
      frame_strobe_o <= next_strobe;
    end
  end

  // Checking helpers
  logic [BPSC_ALIVE_W-1:0] prev_alive;
  logic [BPSC_ALIVE_W-1:0] next_prev_alive;
  logic [BPSC_CNT_W-1:0] gap_cnt;
  logic [BPSC_CNT_W-1:0] next_gap_cnt;

  // Last alive count sent and cycles since the last strobe
  always_comb begin
    next_prev_alive = frame_strobe_o ? frame_o.alive : prev_alive;
    next_gap_cnt = frame_strobe_o ? BPSC_CNT_W'(1) : gap_cnt + BPSC_CNT_W'(1);
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      prev_alive <= BPSC_ALIVE_RST;
      gap_cnt <= '0;
    end else begin
      prev_alive <= next_prev_alive;
      gap_cnt <= next_gap_cnt;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_sent;
    frame_strobe_o;
  endsequence

  chk_init_travel: assert property (s_sent |-> frame_o.init_travel ==
      ($past(sw_s) || ($past(sensor_fitted_i) && $past(pos_s) >= $past(init_thresh_i))))
    else $error("initial travel flag wrong");

  chk_init_switch: assert property (s_sent ##0 !$past(sensor_fitted_i) |->
      frame_o.init_travel == $past(sw_s))
    else $error("initial travel without sensor not from switch");

  chk_init_invalid: assert property (s_sent ##0 frame_o.init_invalid |->
      $past(init_diag_fail_i) && $past(init_fault_stored_i))
    else $error("initial travel invalid without stored fault");

  chk_mod_nosensor: assert property (s_sent ##0 !$past(sensor_fitted_i) |->
      !frame_o.mod_travel && !frame_o.mod_invalid)
    else $error("moderate travel not false and valid without sensor");

  chk_mod_invalid: assert property (s_sent |-> frame_o.mod_invalid ==
      ($past(sensor_fitted_i) && $past(mod_diag_fail_i) && $past(mod_fault_stored_i)))
    else $error("moderate travel validity wrong");

  chk_mod_travel: assert property (s_sent ##0 $past(sensor_fitted_i) |->
      frame_o.mod_travel == ($past(pos_s) >= $past(mod_thresh_i)))
    else $error("moderate travel flag wrong");

  chk_pos_follow: assert property (s_sent ##0 !$past(discrete_only_i) |->
      frame_o.position == $past(pos_s))
    else $error("pedal position not passed on");

  chk_discrete_pos: assert property (s_sent ##0 $past(discrete_only_i) |->
      frame_o.position == ($past(sw_s) ? BPSC_POS_FULL : BPSC_POS_REST))
    else $error("discrete position not at an end point");

  chk_alive_step: assert property (s_sent |->
      frame_o.alive == BPSC_ALIVE_W'(prev_alive + BPSC_ALIVE_STEP))
    else $error("alive count did not advance by one");

  chk_gear_idle: assert property (s_sent ##0 !$past(shift_ctrl_en_i) |->
      frame_o.gear.req_type == BPSC_RT_NONE && frame_o.gear.req_gear == BPSC_GEAR_NONE)
    else $error("gear request sent without shift control");

  chk_gear_legal: assert property (s_sent ##0 frame_o.gear.req_type != BPSC_RT_NONE |->
      frame_o.gear.req_gear >= BPSC_GEAR_FIRST && frame_o.gear.req_gear <= BPSC_GEAR_LAST)
    else $error("active gear request with illegal gear");

  sequence s_gear_asked;
    s_sent ##0 $past(shift_ctrl_en_i) && $past(gear_req_i.req_type) != BPSC_RT_NONE;
  endsequence

  chk_gear_pass: assert property (s_gear_asked ##0
      $past(gear_req_i.req_gear) >= BPSC_GEAR_FIRST
      && $past(gear_req_i.req_gear) <= BPSC_GEAR_LAST
      |-> frame_o.gear == $past(gear_req_i))
    else $error("legal gear request not passed on");

  chk_gear_reject: assert property (s_gear_asked ##0
      ($past(gear_req_i.req_gear) < BPSC_GEAR_FIRST
      || $past(gear_req_i.req_gear) > BPSC_GEAR_LAST)
      |-> frame_o.gear.req_type == BPSC_RT_NONE && frame_o.gear.req_gear == BPSC_GEAR_NONE)
    else $error("reserved gear request passed on");

  chk_strobe_pulse: assert property (s_sent |=> !frame_strobe_o)
    else $error("strobe longer than one cycle");

  chk_tx_period: assert property (
      frame_strobe_o == (gap_cnt == BPSC_CNT_W'(TX_PERIOD_CYC)))
    else $error("transmission period wrong");

  chk_frame_hold: assert property (!frame_strobe_o |-> $stable(frame_o))
    else $error("frame changed without a strobe");

  chk_frame_stable: assert property (s_sent |=> $stable(frame_o) [*8])
    else $error("frame changed between transmissions");

endmodule // bpsc_top

// ==== bpsc_rx_model.sv ====
`timescale 1ns/10ps
module bpsc_rx_model import bpsc_pkg::*; #(
  parameter bit ACC_EN = 1'b0,
  parameter bit POS_CAL_EN = 1'b0,
  parameter int unsigned HOLD_CYC = 8
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire bpsc_frame_t frame_i,
  input wire logic frame_strobe_i,
  output logic cruise_off_o,
  output logic fallback_o,
  output logic gear_use_o,
  output logic pos_use_o
);
  int unsigned wait_cnt;
  int unsigned bad_cnt;
  logic brake_seen;
  assign brake_seen = frame_i.init_travel && !frame_i.init_invalid;
  assign fallback_o = frame_i.init_invalid || frame_i.mod_invalid;
  assign gear_use_o = (frame_i.gear.req_type != BPSC_RT_NONE) &&
    (frame_i.gear.req_gear inside {[BPSC_GEAR_FIRST:BPSC_GEAR_LAST]});
  assign pos_use_o = POS_CAL_EN;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wait_cnt <= 0;
      bad_cnt <= 0;
      cruise_off_o <= 1'b0;
    end else begin
      if (frame_strobe_i) begin
        bad_cnt <= frame_i.init_invalid ? bad_cnt + 1 : 0;
      end
      wait_cnt <= brake_seen ? wait_cnt + 1 : 0;
      cruise_off_o <= (brake_seen && (!ACC_EN || wait_cnt >= HOLD_CYC)) || bad_cnt >= 2;
    end
  end
endmodule // bpsc_rx_model

// ==== tb.sv ====
`timescale 1ns/10ps
module tb import bpsc_pkg::*;;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] pos = 8'h00;
  logic sw = 1'b0;
  logic fit = 1'b1;
  logic disc = 1'b0;
  logic [3:0] dg = 4'h0;
  logic sce = 1'b0;
  bpsc_gear_t gr = 6'h00;
  bpsc_frame_t fr;
  logic stb;
  logic rx_off;
  logic rx_fb;
  logic rx_gear;
  logic rx_pos;
  int err_count = 0;
  int total_checks = 0;
  int cyc = 0;
  int last = -1;
  logic [1:0] alv = 2'h0;
  always #10 clk_i = ~clk_i;
  always @(posedge clk_i) cyc <= cyc + 1;
  bpsc_top #(.TX_PERIOD_CYC(16)) i_bpsc_top (.clk_i(clk_i), .rst_i(rst_i),
    .pedal_pos_i(pos), .brake_switch_i(sw), .sensor_fitted_i(fit),
    .discrete_only_i(disc), .init_thresh_i(8'h80), .mod_thresh_i(8'h40),
    .init_diag_fail_i(dg[3]), .init_fault_stored_i(dg[2]), .mod_diag_fail_i(dg[1]),
    .mod_fault_stored_i(dg[0]), .shift_ctrl_en_i(sce), .gear_req_i(gr),
    .frame_o(fr), .frame_strobe_o(stb));
  bpsc_rx_model i_bpsc_rx_model (.clk_i(clk_i), .rst_i(rst_i), .frame_i(fr),
    .frame_strobe_i(stb), .cruise_off_o(rx_off), .fallback_o(rx_fb), .gear_use_o(rx_gear),
    .pos_use_o(rx_pos));
  task automatic chk(input string nm, input logic [19:0] s, input logic [19:0] e);
    total_checks++;
    if (s !== e) begin
      err_count++;
      $display("ERROR %s exp %h seen %h", nm, e, s);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic frm;
    int n;
    for (n = 0; n < 40; n++) begin
      @(posedge clk_i);
      #1;
      if (stb === 1'b1) break;
    end
    chk("strobe", 20'(stb), 20'h0_0001);
    alv = alv + 2'h1;
    chk("alive", 20'(fr.alive), 20'(alv));
    if (last >= 0) chk("period", 20'(cyc - last), 20'h0_0010);
    last = cyc;
    @(negedge clk_i);
  endtask
  task automatic ap(input logic [7:0] p, input logic s, input logic f, input logic d);
    pos = p;
    sw = s;
    fit = f;
    disc = d;
    frm();
    frm();
  endtask
  task automatic t_init;
    ap(8'h7f, 1'b0, 1'b1, 1'b0);
    chk("init_lo", 20'(fr.init_travel), 20'h0_0000);
    chk("rx_off_lo", 20'(rx_off), 20'h0_0000);
    ap(8'h80, 1'b0, 1'b1, 1'b0);
    chk("init_hi", 20'(fr.init_travel), 20'h0_0001);
    chk("rx_off_hi", 20'(rx_off), 20'h0_0001);
    ap(8'h00, 1'b1, 1'b1, 1'b0);
    chk("init_sw", 20'(fr.init_travel), 20'h0_0001);
  endtask
  task automatic t_mod;
    ap(8'h40, 1'b0, 1'b1, 1'b0);
    chk("mod_hi", 20'({fr.mod_travel, fr.mod_invalid}), 20'h0_0002);
    dg = 4'h3;
    ap(8'hff, 1'b0, 1'b0, 1'b0);
    chk("mod_nosens", 20'({fr.mod_travel, fr.mod_invalid}), 20'h0_0000);
    chk("init_nosens", 20'(fr.init_travel), 20'h0_0000);
    chk("rx_fb_nosens", 20'(rx_fb), 20'h0_0000);
    dg = 4'h0;
  endtask
  task automatic t_val;
    for (int i = 0; i < 4; i++) begin
      dg = {i[1:0], i[1:0]};
      ap(8'h00, 1'b0, 1'b1, 1'b0);
      chk("init_inv", 20'(fr.init_invalid), 20'(i == 3));
      chk("mod_inv", 20'(fr.mod_invalid), 20'(i == 3));
      chk("mod_lo", 20'(fr.mod_travel), 20'h0_0000);
      chk("rx_fb", 20'(rx_fb), 20'(i == 3));
      repeat (2) @(negedge clk_i);
      chk("rx_off_inv", 20'(rx_off), 20'(i == 3));
    end
    dg = 4'h0;
  endtask
  task automatic t_pos;
    ap(8'h5a, 1'b0, 1'b1, 1'b0);
    chk("pos", 20'(fr.position), 20'h0_005a);
    chk("rx_pos", 20'(rx_pos), 20'h0_0000);
    ap(8'h5a, 1'b0, 1'b1, 1'b1);
    chk("pos_rel", 20'(fr.position), 20'h0_0000);
    ap(8'h5a, 1'b1, 1'b1, 1'b1);
    chk("pos_dep", 20'(fr.position), 20'h0_00ff);
  endtask
  task automatic t_gear;
    logic [3:0] gl [5] = '{4'h0, 4'h1, 4'h8, 4'h9, 4'hf};
    logic ok;
    sce = 1'b1;
    for (int t = 0; t < 4; t++) begin
      foreach (gl[k]) begin
        gr = {t[1:0], gl[k]};
        ap(8'h00, 1'b0, 1'b1, 1'b0);
        ok = (t != 0) && (gl[k] inside {[4'h1:4'h8]});
        chk("gear", 20'(fr.gear), ok ? 20'({t[1:0], gl[k]}) : 20'h0_0000);
        chk("rx_gear", 20'(rx_gear), 20'(ok));
      end
    end
    sce = 1'b0;
    gr = 6'h13;
    ap(8'h00, 1'b0, 1'b1, 1'b0);
    chk("gear_off", 20'(fr.gear), 20'h0_0000);
  endtask
  initial begin
    repeat (2) @(negedge clk_i);
    chk("rst", fr, 20'h0_0000);
    rst_i = 1'b0;
    t_init();
    t_mod();
    t_val();
    t_pos();
    t_gear();
    end_sim();
  end
  initial begin
    #100000;
    err_count++;
    end_sim();
  end
endmodule // tb
